//--- rtl/pmc_mode_cfg.sv
// Purpose: Mode selection and management addressing of a quad-port PHY.
// Assumes: Control bits arrive as plain same-clock ports; straps are pins.
// Notes: Write strobes are one cycle; port_sel picks the target port, or bcast_en targets all ports at once.

module pmc_mode_cfg
  import pmc_pkg::*;
#(
  parameter int PORTS = PMC_PORTS
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] port_sel,
  input wire logic bcast_en,
  input wire logic mac_mode_wr,
  input wire logic [1:0] mac_mode_val,
  input wire logic media_wr,
  input wire logic [2:0] media_val,
  input wire logic xsel_wr,
  input wire logic xsel_val,
  input wire logic soft_rst_set,
  input wire logic [PORTS-1:0] mac_an_en,
  input wire logic [PORTS-1:0] media_an_en,
  input wire logic [PORTS-1:0] unidir_en,
  input wire logic [PORTS-1:0] ams_en,
  input wire logic [PORTS-1:0] link_ok,
  input wire logic [PORTS-1:0] sig_detect,
  input wire logic [PORTS-1:0] test_en,
  input wire logic addr_reverse,
  input wire logic [3:0] board_address_strap,
  output logic [1:0] mac_mode_rd,
  output logic [PORTS*3-1:0] media_rd,
  output logic [PORTS-1:0] xsel_rd,
  output logic [PORTS-1:0] soft_rst_rd,
  output logic [PORTS-1:0] unidir_ability,
  output logic [PORTS-1:0] mac_an_run,
  output logic [PORTS-1:0] clause37_mac,
  output logic [PORTS-1:0] media_an_run,
  output logic [PORTS-1:0] gig_only,
  output logic [PORTS-1:0] qsgmii_lane,
  output logic [PORTS-1:0] fiber_tx_en,
  output logic [PORTS-1:0] pxfer_link,
  output logic [PORTS-1:0] led_col_ok,
  output logic [PORTS-1:0] test_run,
  output logic qsgmii_mode,
  output logic [PORTS*5-1:0] mgmt_addr
);

  // ----------------------------------------------------------------
  // Strap and signal detect synchronisers
  // ----------------------------------------------------------------
  logic [3:0] strap_s1_ff;
  logic [3:0] strap_s2_ff;
  logic [PORTS-1:0] sd_s1_ff;
  logic [PORTS-1:0] sd_s2_ff;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      strap_s1_ff <= 4'h0;
      strap_s2_ff <= 4'h0;
      sd_s1_ff <= '0;
      sd_s2_ff <= '0;
    end
    else
    begin
      strap_s1_ff <= board_address_strap;
      strap_s2_ff <= strap_s1_ff;
      sd_s1_ff <= sig_detect;
      sd_s2_ff <= sd_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Global MAC mode
  // ----------------------------------------------------------------
  // A single global field; it needs no port reset since no port owns it.
  logic [1:0] mac_mode_ff;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      mac_mode_ff <= PMC_MAC_MODE_RST;
    else if (mac_mode_wr)
      mac_mode_ff <= mac_mode_val;
  end

  wire is_qsgmii = (mac_mode_ff == PMC_MAC_QSGMII);
  wire is_sgmii_fam = (mac_mode_ff == PMC_MAC_SGMII);

  // ----------------------------------------------------------------
  // Per-port slices and derived status
  // ----------------------------------------------------------------
  function automatic logic port_hit(input logic [1:0] sel,
    input logic bc, input int idx);
    port_hit = bc || (sel == 2'(idx));
  endfunction

  function automatic logic is_fiber(input logic [2:0] m);
    is_fiber = (m == PMC_MEDIA_1000X) || (m == PMC_MEDIA_100FX);
  endfunction

  logic [PORTS-1:0] nxt_mac_an_run;
  logic [PORTS-1:0] nxt_clause37;
  logic [PORTS-1:0] nxt_media_an;
  logic [PORTS-1:0] nxt_gig_only;
  logic [PORTS-1:0] nxt_qlane;
  logic [PORTS-1:0] nxt_fiber_tx;
  logic [PORTS-1:0] nxt_pxfer;
  logic [PORTS-1:0] nxt_led_col;
  logic [PORTS-1:0] nxt_test;
  logic [PORTS*3-1:0] act_media;
  logic [PORTS-1:0] act_xsel;
  logic [PORTS-1:0] srst_busy;
  logic [PORTS*5-1:0] nxt_addr;
  logic [PORTS*3-1:0] media_rd_ff;
  logic [PORTS-1:0] xsel_rd_ff;
  logic [PORTS-1:0] srst_rd_ff;
  logic [PORTS-1:0] mac_an_ff;
  logic [PORTS-1:0] c37_ff;
  logic [PORTS-1:0] media_an_ff;
  logic [PORTS-1:0] gig_ff;
  logic [PORTS-1:0] qlane_ff;
  logic [PORTS-1:0] ftx_ff;
  logic [PORTS-1:0] pxfer_ff;
  logic [PORTS-1:0] ledc_ff;
  logic [PORTS-1:0] test_ff;
  logic [PORTS*5-1:0] addr_ff;
  logic [PORTS-1:0] ability_ff;

  genvar gi;
  generate
    for (gi = 0; gi < PORTS; gi++)
    begin : g_port
      pmc_port_if pif ();
      wire hit = port_hit(port_sel, bcast_en, gi);
      wire [2:0] med = pif.media_act;
      wire x1000 = is_sgmii_fam && pif.xsel_act;
      wire [4:0] base = {strap_s2_ff, 1'b0};
      // Reversal counts ports down from the top of the four-address group.
      wire [4:0] pnum = addr_reverse ? 5'(PORTS - 1 - gi) : 5'(gi);

      assign pif.wr_media = media_wr && hit;
      assign pif.wr_media_val = media_val;
      assign pif.wr_xsel = xsel_wr && hit;
      assign pif.wr_xsel_val = xsel_val;
      assign pif.srst_req = soft_rst_set && hit;

      pmc_port_slice i_pmc_port_slice (
        .ref_clk(ref_clk),
        .rst(rst),
        .pif(pif)
      );

      assign act_media[gi*3 +: 3] = med;
      assign act_xsel[gi] = pif.xsel_act;
      assign srst_busy[gi] = pif.srst_busy;
      // MAC autoneg is held off while a port is still in soft reset.
      assign nxt_mac_an_run[gi] = mac_an_en[gi] && !pif.srst_busy;
      assign nxt_clause37[gi] = x1000 && mac_an_en[gi];
      assign nxt_gig_only[gi] = x1000;
      assign nxt_qlane[gi] = is_qsgmii;
      assign nxt_media_an[gi] = (med == PMC_MEDIA_1000X) &&
        media_an_en[gi] && !unidir_en[gi];
      // Unidirectional transmit ignores link state, but only on fiber and only with ams_en clear.
      assign nxt_fiber_tx[gi] = is_fiber(med) &&
        (link_ok[gi] || (unidir_en[gi] && !ams_en[gi]));
      assign nxt_pxfer[gi] = (med == PMC_MEDIA_PXFER) && sd_s2_ff[gi];
      assign nxt_led_col[gi] = (med != PMC_MEDIA_PXFER);
      assign nxt_test[gi] = test_en[gi] &&
        (is_fiber(med) || med == PMC_MEDIA_CU);
      assign nxt_addr[gi*5 +: 5] = base + pnum;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      media_rd_ff <= '0;
      xsel_rd_ff <= '0;
      srst_rd_ff <= '0;
      mac_an_ff <= '0;
      c37_ff <= '0;
      media_an_ff <= '0;
      gig_ff <= '0;
      qlane_ff <= '0;
      ftx_ff <= '0;
      pxfer_ff <= '0;
      ledc_ff <= '0;
      test_ff <= '0;
      addr_ff <= '0;
      ability_ff <= {PORTS{1'b1}};
    end
    else
    begin
      media_rd_ff <= act_media;
      xsel_rd_ff <= act_xsel;
      srst_rd_ff <= srst_busy;
      mac_an_ff <= nxt_mac_an_run;
      c37_ff <= nxt_clause37;
      media_an_ff <= nxt_media_an;
      gig_ff <= nxt_gig_only;
      qlane_ff <= nxt_qlane;
      ftx_ff <= nxt_fiber_tx;
      pxfer_ff <= nxt_pxfer;
      ledc_ff <= nxt_led_col;
      test_ff <= nxt_test;
      addr_ff <= nxt_addr;
      // The ability never changes, but a flop keeps every output registered.
      ability_ff <= {PORTS{1'b1}};
    end
  end

  assign mac_mode_rd = mac_mode_ff;
  assign qsgmii_mode = qlane_ff[0];
  assign media_rd = media_rd_ff;
  assign xsel_rd = xsel_rd_ff;
  assign soft_rst_rd = srst_rd_ff;
  assign unidir_ability = ability_ff;
  assign mac_an_run = mac_an_ff;
  assign clause37_mac = c37_ff;
  assign media_an_run = media_an_ff;
  assign gig_only = gig_ff;
  assign qsgmii_lane = qlane_ff;
  assign fiber_tx_en = ftx_ff;
  assign pxfer_link = pxfer_ff;
  assign led_col_ok = ledc_ff;
  assign test_run = test_ff;
  assign mgmt_addr = addr_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_an_gated: assert property (@(posedge ref_clk) disable iff (rst)
    !mac_an_en[0] |=> !mac_an_run[0])
    else $error("MAC autoneg ran without enable.");

  a_unidir_tx: assert property (@(posedge ref_clk) disable iff (rst)
    unidir_en[0] && !ams_en[0] && is_fiber(act_media[2:0])
    |=> fiber_tx_en[0])
    else $error("Unidirectional fiber transmit missing.");

  a_addr_port1: assert property (@(posedge ref_clk) disable iff (rst)
    !addr_reverse ##1 $stable(strap_s2_ff)
    |-> mgmt_addr[9:5] == {strap_s2_ff, 1'b0} + 5'h1)
    else $error("Port one address wrong.");

  a_gig_mode: assert property (@(posedge ref_clk) disable iff (rst)
    mac_mode_ff == PMC_MAC_SGMII && act_xsel[0] |=> gig_only[0])
    else $error("1000BASE-X MAC not gigabit only.");

  a_sgmii_rates: assert property (@(posedge ref_clk) disable iff (rst)
    !act_xsel[0] |=> !gig_only[0])
    else $error("SGMII port forced to gigabit.");

  a_qsgmii_sel: assert property (@(posedge ref_clk) disable iff (rst)
    mac_mode_ff == PMC_MAC_QSGMII |=> qsgmii_mode)
    else $error("QSGMII mode not reported.");

  a_pxfer_sd: assert property (@(posedge ref_clk) disable iff (rst)
    !sd_s2_ff[0] |=> !pxfer_link[0])
    else $error("Transfer link without signal detect.");

  a_srst_clear: assert property (@(posedge ref_clk) disable iff (rst)
    soft_rst_set && port_sel == 2'h0 ##1 !soft_rst_set [*8]
    |-> !soft_rst_rd[0])
    else $error("Soft reset bit did not clear.");

  a_media_an_gate: assert property (@(posedge ref_clk) disable iff (rst)
    !media_an_en[1] || unidir_en[1] |=> !media_an_run[1])
    else $error("Media autoneg ran while disabled.");

  a_pxfer_led: assert property (@(posedge ref_clk) disable iff (rst)
    act_media[11:9] == PMC_MEDIA_PXFER |=> !led_col_ok[3])
    else $error("Collision LED allowed in transfer mode.");

  a_test_fiber: assert property (@(posedge ref_clk) disable iff (rst)
    test_en[0] && is_fiber(act_media[2:0]) |=> test_run[0])
    else $error("Test features blocked in fiber mode.");

  a_qlane_all: assert property (@(posedge ref_clk) disable iff (rst)
    is_qsgmii |=> qsgmii_lane == {PORTS{1'b1}})
    else $error("Not every port carried on the quad link.");

endmodule // pmc_mode_cfg

//--- rtl/pmc_pkg.sv
// Purpose: Shared constants for the quad-port SerDes mode configuration.
// Assumes: One 200 MHz clock, synchronous active-high reset.
// Notes: Field codes and reset values used by the mode logic.
package pmc_pkg;

  localparam int PMC_PORTS = 4;
  localparam logic [1:0] PMC_MAC_SGMII = 2'h0;
  localparam logic [1:0] PMC_MAC_QSGMII = 2'h1;
  localparam logic [2:0] PMC_MEDIA_CU = 3'h0;
  localparam logic [2:0] PMC_MEDIA_PXFER = 3'h1;
  localparam logic [2:0] PMC_MEDIA_1000X = 3'h2;
  localparam logic [2:0] PMC_MEDIA_100FX = 3'h3;
  localparam logic [1:0] PMC_MAC_MODE_RST = 2'h0;
  localparam logic [2:0] PMC_MEDIA_RST = 3'h0;
  localparam logic [1:0] PMC_SPEED_10 = 2'h0;
  localparam logic [1:0] PMC_SPEED_100 = 2'h1;
  localparam logic [1:0] PMC_SPEED_1000 = 2'h2;
  // Soft reset hold time in ns and its cycle count at 200 MHz.
  localparam int PMC_SRST_NS = 20;
  localparam int PMC_CLK_MHZ = 200;
  localparam int PMC_SRST_CYC = (PMC_SRST_NS * PMC_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] PMC_SRST_CNT = 4'(PMC_SRST_CYC);

endpackage

//--- rtl/pmc_port_if.sv
// Purpose: Per-port mode bundle between top and port slice.
// Assumes: Same clock domain on both sides.
// Notes: The top drives the requests, the slice returns the active state.
interface pmc_port_if;
  logic wr_media;
  logic [2:0] wr_media_val;
  logic wr_xsel;
  logic wr_xsel_val;
  logic srst_req;
  logic [2:0] media_act;
  logic xsel_act;
  logic srst_busy;
  modport top (output wr_media, wr_media_val, wr_xsel, wr_xsel_val,
    srst_req, input media_act, xsel_act, srst_busy);
  modport slice (input wr_media, wr_media_val, wr_xsel, wr_xsel_val,
    srst_req, output media_act, xsel_act, srst_busy);
endinterface

//--- rtl/pmc_port_slice.sv
// Purpose: One port's pending and active mode with soft reset sequencing.
// Assumes: Writes arrive as single-cycle strobes.
// Notes: The pending value only becomes active at the end of soft reset.
module pmc_port_slice
  import pmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  pmc_port_if.slice pif
);

  logic [2:0] pend_media_ff;
  logic pend_xsel_ff;
  logic [2:0] act_media_ff;
  logic act_xsel_ff;
  logic [3:0] srst_cnt_ff;
  logic [3:0] nxt_srst_cnt;
  wire srst_done = (srst_cnt_ff == 4'h1);

  // Reset restarts the count, so a second request only lengthens it.
  assign nxt_srst_cnt = pif.srst_req ? PMC_SRST_CNT :
    (srst_cnt_ff != 4'h0) ? srst_cnt_ff - 4'h1 : 4'h0;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pend_media_ff <= PMC_MEDIA_RST;
      pend_xsel_ff <= 1'b0;
      act_media_ff <= PMC_MEDIA_RST;
      act_xsel_ff <= 1'b0;
      srst_cnt_ff <= 4'h0;
    end
    else
    begin
      if (pif.wr_media)
        pend_media_ff <= pif.wr_media_val;
      if (pif.wr_xsel)
        pend_xsel_ff <= pif.wr_xsel_val;
      srst_cnt_ff <= nxt_srst_cnt;
      if (srst_done)
      begin
        act_media_ff <= pend_media_ff;
        act_xsel_ff <= pend_xsel_ff;
      end
    end
  end

  assign pif.media_act = act_media_ff;
  assign pif.xsel_act = act_xsel_ff;
  assign pif.srst_busy = (srst_cnt_ff != 4'h0);

  a_mode_holds: assert property (@(posedge ref_clk) disable iff (rst)
    !srst_done |=> $stable(act_media_ff))
    else $error("Active media mode changed without soft reset.");

  a_srst_busy_len: assert property (@(posedge ref_clk) disable iff (rst)
    pif.srst_req ##1 !pif.srst_req [*2] |-> pif.srst_busy)
    else $error("Soft reset ended too early.");

endmodule // pmc_port_slice

//--- tb/pmc_mac_model.sv
// Purpose: Far-side model that drives signal detect and link state.
// Assumes: Same clock as the block; the bench commands each level.
// Notes: Lines change only just after a clock edge, as a module would.
module pmc_mac_model
  import pmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [PMC_PORTS-1:0] sd_cmd,
  input wire logic [PMC_PORTS-1:0] link_cmd,
  output logic [PMC_PORTS-1:0] sig_detect,
  output logic [PMC_PORTS-1:0] link_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // Signal detect rises only when commanded, so no link is implied early.
  always_ff @(posedge ref_clk)
  begin
    sig_detect <= sd_cmd;
    link_ok <= link_cmd;
  end
endmodule // pmc_mac_model

//--- tb/tb_phy_serdes_mode_config.sv
// Purpose: Self-checking bench for the SerDes mode configuration block.
// Assumes: 200 MHz clock, synchronous active-high reset.
// Notes: Each scenario is a task that drives and judges by itself.
module tb_phy_serdes_mode_config
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] port_sel = 2'h0;
  logic [1:0] mac_mode_val = 2'h0;
  logic [2:0] media_val = 3'h0;
  logic bcast_en = 1'b0;
  logic mac_mode_wr = 1'b0;
  logic media_wr = 1'b0;
  logic xsel_wr = 1'b0;
  logic xsel_val = 1'b0;
  logic soft_rst_set = 1'b0;
  logic addr_reverse = 1'b0;
  logic [3:0] mac_an_en = 4'h0;
  logic [3:0] media_an_en = 4'h0;
  logic [3:0] unidir_en = 4'h0;
  logic [3:0] ams_en = 4'h0;
  logic [3:0] test_en = 4'h0;
  logic [3:0] sd_cmd = 4'h0;
  logic [3:0] link_cmd = 4'h0;
  logic [3:0] board_address_strap = 4'ha;
  logic [3:0] sig_detect, link_ok, xsel_rd, soft_rst_rd, unidir_ability;
  logic [3:0] mac_an_run, clause37_mac, media_an_run, gig_only, test_run;
  logic [3:0] fiber_tx_en, pxfer_link, led_col_ok, qsgmii_lane;
  logic [15:0] serdes_cmd = 16'h0;
  logic [1:0] adv_10_100 = 2'h3;
  logic [1:0] mac_mode_rd;
  logic [11:0] media_rd;
  logic [19:0] mgmt_addr;
  logic qsgmii_mode;
  int mismatches = 0;
  int cmp_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  pmc_mac_model i_pmc_mac_model (.ref_clk(ref_clk), .sd_cmd(sd_cmd),
    .link_cmd(link_cmd), .sig_detect(sig_detect), .link_ok(link_ok));
  pmc_mode_cfg i_pmc_mode_cfg (.ref_clk(ref_clk), .rst(rst),
    .port_sel(port_sel), .bcast_en(bcast_en), .mac_mode_wr(mac_mode_wr),
    .mac_mode_val(mac_mode_val), .media_wr(media_wr),
    .media_val(media_val), .xsel_wr(xsel_wr), .xsel_val(xsel_val),
    .soft_rst_set(soft_rst_set), .mac_an_en(mac_an_en),
    .media_an_en(media_an_en), .unidir_en(unidir_en), .ams_en(ams_en),
    .link_ok(link_ok), .sig_detect(sig_detect), .test_en(test_en),
    .addr_reverse(addr_reverse), .board_address_strap(board_address_strap),
    .mac_mode_rd(mac_mode_rd), .media_rd(media_rd), .xsel_rd(xsel_rd),
    .soft_rst_rd(soft_rst_rd), .unidir_ability(unidir_ability),
    .mac_an_run(mac_an_run), .clause37_mac(clause37_mac),
    .media_an_run(media_an_run), .gig_only(gig_only),
    .qsgmii_lane(qsgmii_lane),
    .fiber_tx_en(fiber_tx_en), .pxfer_link(pxfer_link),
    .led_col_ok(led_col_ok), .test_run(test_run),
    .qsgmii_mode(qsgmii_mode), .mgmt_addr(mgmt_addr));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Observation waits 1 ns past the edge so its updates have landed.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic strobe(input int k, input logic [1:0] p, input logic bc,
    input logic [2:0] v);
    @(posedge ref_clk);
    port_sel <= p;
    bcast_en <= bc;
    mac_mode_val <= v[1:0];
    media_val <= v;
    xsel_val <= v[0];
    case (k)
      0: mac_mode_wr <= 1'b1;
      1: media_wr <= 1'b1;
      2: xsel_wr <= 1'b1;
      default: soft_rst_set <= 1'b1;
    endcase
    @(posedge ref_clk);
    {mac_mode_wr, media_wr, xsel_wr, soft_rst_set} <= 4'h0;
  endtask
  // Busy must rise, the old mode must stand meanwhile, then busy clears.
  task automatic srst(input logic [1:0] p, input logic bc,
    input logic [2:0] old);
    int n;
    n = 0;
    strobe(3, p, bc, 3'h0);
    tick(0);
    while (soft_rst_rd[p] !== 1'b1 && n < 8)
    begin
      tick(1);
      n++;
    end
    chk(soft_rst_rd[p], 1'b1);
    chk(media_rd[3*p +: 3], old);
    while (soft_rst_rd[p] !== 1'b0 && n < 24)
    begin
      tick(1);
      n++;
    end
    chk(soft_rst_rd[p], 1'b0);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(mac_mode_rd, PMC_MAC_MODE_RST);
    chk({media_rd, xsel_rd, soft_rst_rd}, 20'h0);
    chk(unidir_ability, 4'hf);
  endtask
  task automatic t_media;
    strobe(1, 2'h1, 1'b0, PMC_MEDIA_1000X);
    tick(3);
    chk(media_rd, 12'h0);
    srst(2'h1, 1'b0, PMC_MEDIA_RST);
    chk(media_rd, 12'h010);
    media_an_en <= 4'h2;
    tick(3);
    chk(media_an_run[1], 1'b1);
    media_an_en <= 4'h0;
    tick(3);
    chk(media_an_run[1], 1'b0);
  endtask
  task automatic t_mac;
    // Software side of the gigabit MAC set-up, done before the select bit.
    serdes_cmd <= 16'h80f0;
    adv_10_100 <= 2'h0;
    strobe(2, 2'h2, 1'b0, 3'h1);
    tick(2);
    chk(xsel_rd, 4'h0);
    srst(2'h2, 1'b0, PMC_MEDIA_RST);
    chk(xsel_rd, 4'h4);
    chk(gig_only, 4'h4);
    mac_an_en <= 4'h4;
    tick(3);
    chk(mac_an_run, 4'h4);
    chk(clause37_mac[2], 1'b1);
    strobe(0, 2'h0, 1'b0, {1'b0, PMC_MAC_QSGMII});
    tick(3);
    chk(mac_mode_rd, PMC_MAC_QSGMII);
    chk(qsgmii_mode, 1'b1);
    chk(qsgmii_lane, 4'hf);
    chk(gig_only, 4'h0);
    mac_an_en <= 4'h0;
    strobe(0, 2'h0, 1'b0, {1'b0, PMC_MAC_SGMII});
    tick(3);
    chk(mac_mode_rd, PMC_MAC_SGMII);
  endtask
  task automatic t_bcast;
    strobe(1, 2'h3, 1'b1, PMC_MEDIA_100FX);
    strobe(2, 2'h3, 1'b1, 3'h1);
    srst(2'h0, 1'b1, PMC_MEDIA_RST);
    chk(media_rd, {4{PMC_MEDIA_100FX}});
    chk(xsel_rd, 4'hf);
    chk(gig_only, 4'hf);
    test_en <= 4'hf;
    tick(3);
    chk(test_run, 4'hf);
  endtask
  task automatic t_unidir;
    // Far side keeps autoneg and media sensing off in this mode.
    unidir_en <= 4'h5;
    tick(4);
    chk(fiber_tx_en, 4'h5);
    link_cmd <= 4'hf;
    tick(4);
    chk(fiber_tx_en, 4'hf);
    unidir_en <= 4'h0;
  endtask
  task automatic t_pxfer;
    strobe(1, 2'h3, 1'b0, PMC_MEDIA_PXFER);
    srst(2'h3, 1'b0, PMC_MEDIA_100FX);
    tick(4);
    chk(pxfer_link[3], 1'b0);
    sd_cmd <= 4'h8;
    tick(6);
    chk(pxfer_link[3], 1'b1);
    chk(led_col_ok[3], 1'b0);
  endtask
  task automatic t_addr;
    chk(mgmt_addr, {5'h17, 5'h16, 5'h15, 5'h14});
    addr_reverse <= 1'b1;
    tick(4);
    chk(mgmt_addr, {5'h14, 5'h15, 5'h16, 5'h17});
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    tick(1);
    t_reset;
    t_media;
    t_mac;
    t_bcast;
    t_unidir;
    t_pxfer;
    t_addr;
    end_sim;
  end
  // The tests need about a hundred cycles; 5000 leaves ample margin.
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    end_sim;
  end
endmodule // tb_phy_serdes_mode_config
